// [hw/drb_pkg.sv]
// shared constants, types and helpers for the burst link
package drb_pkg;
    // clock period
    localparam real CLK_NS = 10.0;
    // command encodings on the link
    typedef enum logic [2:0] {
        DRB_NOP = 3'h0,
        DRB_ACT = 3'h1,
        DRB_RD = 3'h2,
        DRB_WR = 3'h3,
        DRB_PRE = 3'h4
    } drb_cmd_t;
    // burst-length mode field values
    localparam logic [1:0] BL_FIX8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIX4 = 2'h2;
    // field positions inside the address word
    localparam int ADDR_W = 14;
    localparam int COL_W = 10;
    localparam int A12_POS = 12;
    // link widths: two beats of 16 bits per clock, one mask bit per byte
    localparam int DQ_W = 32;
    localparam int DM_W = 4;
    localparam int LAT_DEPTH = 64;
    // interval figures in their own unit
    localparam real TRTP_NS = 7.5;
    localparam int TRTP_MIN_CK = 4;
    localparam real TRCD_NS = 15.0;
    localparam real TRP_NS = 15.0;
    localparam real TRAS_NS = 40.0;
    localparam real TRC_NS = 55.0;
    localparam real TWR_NS = 15.0;
    localparam int CCD_CK = 4;
    // least times round up to whole cycles, never below one
    function automatic int ceil_cyc(input real ns);
        int c;
        c = $rtoi(ns / CLK_NS);
        if (c * CLK_NS < ns) begin
            c = c + 1;
        end
        if (c < 1) begin
            c = 1;
        end
        return c;
    endfunction
    localparam int TRTP_CYC = (ceil_cyc(TRTP_NS) > TRTP_MIN_CK) ? ceil_cyc(TRTP_NS) : TRTP_MIN_CK;
    localparam int TRCD_CYC = ceil_cyc(TRCD_NS);
    localparam int TRP_CYC = ceil_cyc(TRP_NS);
    localparam int TRAS_CYC = ceil_cyc(TRAS_NS);
    localparam int TRC_CYC = ceil_cyc(TRC_NS);
    localparam int TWR_CYC = ceil_cyc(TWR_NS);
    // chop decision from mode field and the a12 level at the command
    function automatic logic is_bc4(input logic [1:0] mode, input logic a12);
        case (mode)
            BL_FIX8: is_bc4 = 1'b0;
            BL_OTF: is_bc4 = ~a12;
            BL_FIX4: is_bc4 = 1'b1;
            default: is_bc4 = 1'b0;
        endcase
    endfunction
    // column of one beat: full burst in order, chop picks a nibble with col[2]
    function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] col,
                                                  input logic c4, input logic [2:0] j);
        if (c4) begin
            beat_col = {col[COL_W-1:3], col[2], j[1:0]};
        end else begin
            beat_col = {col[COL_W-1:3], j};
        end
    endfunction
endpackage : drb_pkg

// [hw/drb_if.sv]
// link between controller and memory device, with wire resolution
interface drb_if;
    import drb_pkg::*;
    drb_cmd_t cmd;              // command each clock
    logic [2:0] ba;             // bank
    logic [ADDR_W-1:0] addr;    // row or column plus a12
    logic [DQ_W-1:0] ctl_dq_o;  // controller data drive
    logic ctl_dq_oe_n;          // low while controller drives data
    logic [DM_W-1:0] ctl_dm_o;  // write mask, one bit per byte
    logic ctl_dqs_o;            // controller strobe
    logic ctl_dqs_oe_n;         // low while controller drives strobe
    logic [DQ_W-1:0] dev_dq_o;  // device data drive
    logic dev_dq_oe_n;          // low while device drives data
    logic dev_dqs_o;            // device strobe
    logic dev_dqs_oe_n;         // low while device drives strobe
    logic [DQ_W-1:0] dq;        // resolved data wire
    logic dqs;                  // resolved strobe wire
    // device wins when both drive; a clash is a protocol fault anyway
    assign dq = !dev_dq_oe_n ? dev_dq_o : (!ctl_dq_oe_n ? ctl_dq_o : '0);
    assign dqs = !dev_dqs_oe_n ? dev_dqs_o : (!ctl_dqs_oe_n ? ctl_dqs_o : 1'b0);
    modport ctl (output cmd, ba, addr, ctl_dq_o, ctl_dq_oe_n, ctl_dm_o, ctl_dqs_o,
                 ctl_dqs_oe_n, input dq, dqs);
    modport dev (input cmd, ba, addr, ctl_dm_o, ctl_dqs_oe_n, dq, dqs,
                 output dev_dq_o, dev_dq_oe_n, dev_dqs_o, dev_dqs_oe_n);
endinterface : drb_if

// [hw/drb_dev.sv]
// memory device end: command latency line, burst engine and array
// How it works
// - with field 01, a12 low chops to four, high gives eight
// - controller keeps four clocks between column commands
// - a12 never enters the column address
// - field 00, or 01 with a12 high: eight
// - read to precharge at least al plus trtp
// - precharge also waits for activate-to-precharge time
// - reactivate after precharge time and cycle time
// - one mask bit per byte masks writes
// - mask ignored during reads
// - bad data timing corrupts only addressed location
// - bad strobe timing corrupts only that burst
// - read data starts al plus cl later
// - field 10 always chops to four
module drb_dev
    import drb_pkg::*;
#(
    parameter int ROW_W = 2,
    parameter int LAT_D = LAT_DEPTH
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // link to the controller
    drb_if.dev link,
    // mode settings, held steady while traffic runs
    input wire logic [1:0] bl_mode_in,
    input wire logic [4:0] al_in,
    input wire logic [4:0] cl_in,
    input wire logic [4:0] cwl_in,
    // status
    output logic wr_bad_out
);
    localparam int MEM_AW = 3 + ROW_W + COL_W;
    localparam int MEM_N = 1 << MEM_AW;

    // one pending column command in the latency line
    typedef struct packed {
        logic v;
        logic w;
        logic c4;
        logic [2:0] ba;
        logic [COL_W-1:0] col;
    } drb_ent_t;

    drb_ent_t dl_ff [LAT_D];            // latency line, index 0 newest
    logic [ROW_W-1:0] row_ff [8];       // open row per bank
    logic [15:0] mem [MEM_N];           // storage, no reset on purpose
    logic act_ff;                       // burst in progress
    logic [1:0] bi_ff;                  // next beat-pair index
    logic cw_ff;                        // held: write burst
    logic c4_ff;                        // held: chopped burst
    logic [2:0] cba_ff;                 // held bank
    logic [COL_W-1:0] ccol_ff;          // held column
    logic [DQ_W-1:0] dq_o_ff;           // read data drive
    logic oe_n_ff;                      // read drive enable, low active
    logic dqs_o_ff;                     // read strobe
    logic bad_ff;                       // strobe fault seen this beat
    logic [5:0] rl;                     // read latency
    logic [5:0] wl;                     // write latency
    drb_ent_t tap_r;                    // entry due for read launch
    drb_ent_t tap_w;                    // entry due for write launch
    logic hit_r;
    logic hit_w;
    logic launch;
    logic beat_now;
    logic [1:0] idx;
    logic [1:0] last;
    logic cur_w;
    logic cur_c4;
    logic [2:0] cur_ba;
    logic [COL_W-1:0] cur_col;
    logic strobe_ok;
    drb_ent_t new_ent;

    // memory address of one beat of the current burst
    function automatic logic [MEM_AW-1:0] mem_addr(input logic [2:0] b,
            input logic [ROW_W-1:0] r, input logic [COL_W-1:0] c,
            input logic c4, input logic [2:0] j);
        mem_addr = {b, r, beat_col(c, c4, j)};
    endfunction

    // latencies from the mode settings
    assign rl = 6'(al_in) + 6'(cl_in);
    assign wl = 6'(al_in) + 6'(cwl_in);

    // decode the command entering the line
    always_comb begin
        new_ent.v = (link.cmd == DRB_RD) || (link.cmd == DRB_WR);
        new_ent.w = (link.cmd == DRB_WR);
        new_ent.c4 = is_bc4(bl_mode_in, link.addr[A12_POS]);
        new_ent.ba = link.ba;
        // only the low column bits; a12 and a10 stay out of the address
        new_ent.col = link.addr[COL_W-1:0];
    end

    // latency line: shifts every clock, so any latency works with overlap
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < LAT_D; i++) begin
                dl_ff[i] <= '0;
            end
        end else begin
            dl_ff[0] <= new_ent;
            for (int i = 1; i < LAT_D; i++) begin
                dl_ff[i] <= dl_ff[i-1];
            end
        end
    end

    // open row per bank, taken on activate
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                row_ff[i] <= '0;
            end
        end else if (link.cmd == DRB_ACT) begin
            row_ff[link.ba] <= link.addr[ROW_W-1:0];
        end
    end

    // read launches one clock early since the drive is registered
    always_comb begin
        tap_r = dl_ff[rl - 6'h2];
        tap_w = dl_ff[wl - 6'h1];
        hit_r = tap_r.v && !tap_r.w;
        hit_w = tap_w.v && tap_w.w;
        launch = hit_r || hit_w;
        beat_now = launch || act_ff;
        idx = launch ? 2'h0 : bi_ff;
        // a write launch wins; overlap is a controller spacing fault
        cur_w = launch ? hit_w : cw_ff;
        cur_c4 = launch ? (hit_w ? tap_w.c4 : tap_r.c4) : c4_ff;
        cur_ba = launch ? (hit_w ? tap_w.ba : tap_r.ba) : cba_ff;
        cur_col = launch ? (hit_w ? tap_w.col : tap_r.col) : ccol_ff;
        last = cur_c4 ? 2'h1 : 2'h3;
        strobe_ok = !link.ctl_dqs_oe_n && link.dqs;
    end

    // burst engine: ends on its own count, so strobe faults never hang it
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            act_ff <= 1'b0;
            bi_ff <= 2'h0;
            cw_ff <= 1'b0;
            c4_ff <= 1'b0;
            cba_ff <= 3'h0;
            ccol_ff <= '0;
        end else begin
            if (beat_now) begin
                act_ff <= (idx != last);
                bi_ff <= idx + 2'h1;
            end
            if (launch) begin
                cw_ff <= cur_w;
                c4_ff <= cur_c4;
                cba_ff <= cur_ba;
                ccol_ff <= cur_col;
            end
        end
    end

    // array writes with byte masking; a beat without strobe is dropped
    always_ff @(posedge clock_in) begin
        if (beat_now && cur_w && strobe_ok) begin
            for (int k = 0; k < 2; k++) begin
                for (int b = 0; b < 2; b++) begin
                    if (!link.ctl_dm_o[k*2+b]) begin
                        mem[mem_addr(cur_ba, row_ff[cur_ba], cur_col, cur_c4,
                            {idx, 1'(k)})][b*8 +: 8] <= link.dq[k*16+b*8 +: 8];
                    end
                end
            end
        end
    end

    // read drive: two beats per clock, mask inputs never looked at
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            dq_o_ff <= '0;
            oe_n_ff <= 1'b1;
            dqs_o_ff <= 1'b0;
        end else if (beat_now && !cur_w) begin
            dq_o_ff <= {mem[mem_addr(cur_ba, row_ff[cur_ba], cur_col, cur_c4, {idx, 1'b1})],
                        mem[mem_addr(cur_ba, row_ff[cur_ba], cur_col, cur_c4, {idx, 1'b0})]};
            oe_n_ff <= 1'b0;
            dqs_o_ff <= 1'b1;
        end else begin
            oe_n_ff <= 1'b1;
            dqs_o_ff <= 1'b0;
        end
    end

    // strobe fault flag, high one clock per lost beat pair
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            bad_ff <= 1'b0;
        end else begin
            bad_ff <= beat_now && cur_w && !strobe_ok;
        end
    end

    assign link.dev_dq_o = dq_o_ff;
    assign link.dev_dq_oe_n = oe_n_ff;
    assign link.dev_dqs_o = dqs_o_ff;
    assign link.dev_dqs_oe_n = oe_n_ff;
    assign wr_bad_out = bad_ff;
endmodule // drb_dev

// [hw/drb_ctl.sv]
// controller end: closed-page sequencer with write drive and read capture
module drb_ctl
    import drb_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // link to the device
    drb_if.ctl link,
    // mode settings, must match the device
    input wire logic [1:0] bl_mode_in,
    input wire logic [4:0] al_in,
    input wire logic [4:0] cl_in,
    input wire logic [4:0] cwl_in,
    // user request
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_bc4_in,
    input wire logic [2:0] req_bank_in,
    input wire logic [ADDR_W-1:0] req_row_in,
    input wire logic [COL_W-1:0] req_col_in,
    input wire logic [4*DQ_W-1:0] req_wdata_in,
    input wire logic [4*DM_W-1:0] req_wmask_in,
    output logic req_ready_out,
    // read answer
    output logic [4*DQ_W-1:0] rd_data_out,
    output logic rd_valid_out
);
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RCD = 5'h02,
        S_PREW = 5'h04,
        S_RP = 5'h08,
        S_CMD = 5'h10
    } drb_st_t;

    drb_st_t st_ff;
    logic [6:0] tmr_ff;                 // state interval countdown
    logic [6:0] ras_ff;                 // activate-to-precharge countdown
    logic [6:0] rc_ff;                  // activate-to-activate countdown
    drb_cmd_t cmd_ff;
    logic [2:0] ba_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic w_ff;                         // held: write request
    logic c4_ff;                        // held: chopped burst
    logic [COL_W-1:0] col_ff;
    logic [4*DQ_W-1:0] wd_ff;
    logic [4*DM_W-1:0] wm_ff;
    logic pend_ff;                      // data phase waiting for latency
    logic [6:0] dcnt_ff;                // latency countdown
    logic dact_ff;                      // data phase running
    logic [1:0] dbi_ff;
    logic [DQ_W-1:0] dq_o_ff;
    logic [DM_W-1:0] dm_o_ff;
    logic oe_n_ff;
    logic [4*DQ_W-1:0] rbuf_ff;
    logic rv_ff;
    logic dbeat;
    logic [1:0] didx;
    logic [1:0] dlast;
    logic [6:0] rl;
    logic [6:0] wl;
    logic dbusy;

    assign rl = 7'(al_in) + 7'(cl_in);
    assign wl = 7'(al_in) + 7'(cwl_in);
    assign dbusy = pend_ff || dact_ff;
    // one access at a time keeps column commands far more than four apart
    assign req_ready_out = (st_ff == S_IDLE) && (rc_ff == 7'h0) && !dbusy;

    // sequencer: act, column command, precharge, precharge wait
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= S_IDLE;
            tmr_ff <= 7'h0;
            cmd_ff <= DRB_NOP;
            ba_ff <= 3'h0;
            addr_ff <= '0;
            w_ff <= 1'b0;
            c4_ff <= 1'b0;
            col_ff <= '0;
            wd_ff <= '0;
            wm_ff <= '0;
        end else begin
            cmd_ff <= DRB_NOP;
            if (tmr_ff != 7'h0) begin
                tmr_ff <= tmr_ff - 7'h1;
            end
            case (st_ff)
                S_IDLE: begin
                    if (req_valid_in && req_ready_out) begin
                        cmd_ff <= DRB_ACT;
                        ba_ff <= req_bank_in;
                        addr_ff <= req_row_in;
                        w_ff <= req_write_in;
                        c4_ff <= is_bc4(bl_mode_in, ~req_bc4_in);
                        col_ff <= req_col_in;
                        wd_ff <= req_wdata_in;
                        wm_ff <= req_wmask_in;
                        tmr_ff <= 7'(TRCD_CYC - 1);
                        st_ff <= S_RCD;
                    end
                end
                S_RCD: begin
                    if (tmr_ff == 7'h0) begin
                        st_ff <= S_CMD;
                    end
                end
                S_CMD: begin
                    cmd_ff <= w_ff ? DRB_WR : DRB_RD;
                    // a12 high asks for eight, low for the chop
                    addr_ff <= '0;
                    addr_ff[COL_W-1:0] <= col_ff;
                    addr_ff[A12_POS] <= ~c4_ff;
                    if (w_ff) begin
                        tmr_ff <= wl + 7'(CCD_CK) + 7'(TWR_CYC);
                    end else begin
                        tmr_ff <= 7'(al_in) + 7'(TRTP_CYC);
                    end
                    st_ff <= S_PREW;
                end
                S_PREW: begin
                    if (tmr_ff == 7'h0 && ras_ff == 7'h0) begin
                        cmd_ff <= DRB_PRE;
                        tmr_ff <= 7'(TRP_CYC);
                        st_ff <= S_RP;
                    end
                end
                S_RP: begin
                    if (tmr_ff == 7'h0) begin
                        st_ff <= S_IDLE;
                    end
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    // activate-side interval counters
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ras_ff <= 7'h0;
            rc_ff <= 7'h0;
        end else if (st_ff == S_IDLE && req_valid_in && req_ready_out) begin
            ras_ff <= 7'(TRAS_CYC);
            rc_ff <= 7'(TRC_CYC);
        end else begin
            if (ras_ff != 7'h0) begin
                ras_ff <= ras_ff - 7'h1;
            end
            if (rc_ff != 7'h0) begin
                rc_ff <= rc_ff - 7'h1;
            end
        end
    end

    // data phase timing: writes load one clock ahead, reads sample on time
    assign dbeat = (pend_ff && dcnt_ff == 7'h0) || dact_ff;
    assign didx = dact_ff ? dbi_ff : 2'h0;
    assign dlast = c4_ff ? 2'h1 : 2'h3;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pend_ff <= 1'b0;
            dcnt_ff <= 7'h0;
            dact_ff <= 1'b0;
            dbi_ff <= 2'h0;
        end else begin
            if (st_ff == S_CMD) begin
                pend_ff <= 1'b1;
                dcnt_ff <= w_ff ? (wl - 7'h1) : rl;
            end else if (pend_ff && dcnt_ff != 7'h0) begin
                dcnt_ff <= dcnt_ff - 7'h1;
            end else if (pend_ff) begin
                pend_ff <= 1'b0;
            end
            if (dbeat) begin
                dact_ff <= (didx != dlast);
                dbi_ff <= didx + 2'h1;
            end
        end
    end

    // write drive: data, mask and strobe share the same timing
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            dq_o_ff <= '0;
            dm_o_ff <= '0;
            oe_n_ff <= 1'b1;
        end else if (dbeat && w_ff) begin
            dq_o_ff <= wd_ff[didx*DQ_W +: DQ_W];
            dm_o_ff <= wm_ff[didx*DM_W +: DM_W];
            oe_n_ff <= 1'b0;
        end else begin
            oe_n_ff <= 1'b1;
            dm_o_ff <= '0;
        end
    end

    // read capture, answer pulses the clock after the last pair
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rbuf_ff <= '0;
            rv_ff <= 1'b0;
        end else begin
            if (dbeat && !w_ff) begin
                rbuf_ff[didx*DQ_W +: DQ_W] <= link.dq;
            end
            rv_ff <= dbeat && !w_ff && (didx == dlast);
        end
    end

    assign link.cmd = cmd_ff;
    assign link.ba = ba_ff;
    assign link.addr = addr_ff;
    assign link.ctl_dq_o = dq_o_ff;
    assign link.ctl_dq_oe_n = oe_n_ff;
    assign link.ctl_dm_o = dm_o_ff;
    assign link.ctl_dqs_o = !oe_n_ff;
    assign link.ctl_dqs_oe_n = oe_n_ff;
    assign rd_data_out = rbuf_ff;
    assign rd_valid_out = rv_ff;
endmodule // drb_ctl

// [verif/drb_chk.sv]
// assertions on the link between controller and device
module drb_chk
    import drb_pkg::*;
#(
    parameter int RL = 6,
    parameter int WL = 5
) (
    // clock, reset, mode
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [1:0] bl_mode_in,
    // link signals
    input wire drb_cmd_t cmd,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic ctl_dq_oe_n,
    input wire logic ctl_dqs_oe_n,
    input wire logic ctl_dqs_o,
    input wire logic [DM_W-1:0] ctl_dm_o,
    input wire logic dev_dq_oe_n,
    input wire logic dev_dqs_o
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // column command decode
    wire logic rd_cmd = cmd == DRB_RD;
    wire logic col_cmd = rd_cmd || cmd == DRB_WR;
    wire logic otf = bl_mode_in == BL_OTF;
    property p_rd_lat;
        rd_cmd |-> ##RL !dev_dq_oe_n && dev_dqs_o;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data off time");
    property p_bl8;
        rd_cmd && (bl_mode_in == BL_FIX8 || otf && addr[A12_POS])
            |-> ##RL (!dev_dq_oe_n)[*4] ##1 dev_dq_oe_n;
    endproperty
    a_bl8: assert property (p_bl8) else $error("full read not eight beats");
    property p_fix4;
        rd_cmd && bl_mode_in == BL_FIX4 |-> ##RL (!dev_dq_oe_n)[*2] ##1 dev_dq_oe_n;
    endproperty
    a_fix4: assert property (p_fix4) else $error("fixed chop not four beats");
    property p_otf4;
        rd_cmd && otf && !addr[A12_POS] |-> ##RL (!dev_dq_oe_n)[*2] ##1 dev_dq_oe_n;
    endproperty
    a_otf4: assert property (p_otf4) else $error("select low did not chop");
    property p_wr;
        cmd == DRB_WR |-> ##WL !ctl_dq_oe_n && !ctl_dqs_oe_n && ctl_dqs_o;
    endproperty
    a_wr: assert property (p_wr) else $error("write data off time");
    property p_dm;
        ctl_dq_oe_n |-> ctl_dm_o == '0;
    endproperty
    a_dm: assert property (p_dm) else $error("mask outside write data");
    property p_ccd;
        col_cmd |=> (!col_cmd)[*3];
    endproperty
    a_ccd: assert property (p_ccd) else $error("column commands too close");
    property p_rtp;
        rd_cmd |=> (cmd != DRB_PRE)[*3];
    endproperty
    a_rtp: assert property (p_rtp) else $error("precharge too soon after read");
    property p_ras;
        cmd == DRB_ACT |=> (cmd != DRB_PRE)[*3];
    endproperty
    a_ras: assert property (p_ras) else $error("precharge too soon after activate");
    property p_rc;
        cmd == DRB_ACT |=> (cmd != DRB_ACT)[*5];
    endproperty
    a_rc: assert property (p_rc) else $error("activate too soon");
    // main scenarios reached
    c_fix4: cover property (rd_cmd && bl_mode_in == BL_FIX4);
    c_otf4: cover property (rd_cmd && otf && !addr[A12_POS]);
    c_wr8: cover property (cmd == DRB_WR && bl_mode_in == BL_FIX8);
endmodule // drb_chk

// [verif/tb_ddr3_read_write_burst.sv]
// bench: controller and device joined, plus a fault lane
module tb_ddr3_read_write_burst
    import drb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int RL = 6;
    localparam int WL = 5;
    localparam logic [31:0] LANE_D = 32'hA5C3_0F96; // fault lane pattern
    logic clock_in, rst_in, v, w, bc, rdy, rv, bad1, bad2; // user side
    // latency levels; the fault lane adds al for a read latency of 11
    logic [4:0] al = 5'h0, cl = 5'h6, cwl = 5'h5, al2 = 5'h5;
    logic [1:0] bm; // burst mode
    logic [2:0] bk;
    logic [13:0] row;
    logic [9:0] col;
    logic [127:0] d, rdat;
    logic [15:0] mk;
    int fail_count = 0, samples_checked = 0, cyc = 0, nbad = 0, nbad1 = 0;
    drb_if lk();
    drb_if lk2(); // driven by the bench to break strobe timing
    drb_ctl drb_ctl_i(.clock_in(clock_in), .rst_in(rst_in), .link(lk), .bl_mode_in(bm),
        .al_in(al), .cl_in(cl), .cwl_in(cwl), .req_valid_in(v), .req_write_in(w),
        .req_bc4_in(bc), .req_bank_in(bk), .req_row_in(row), .req_col_in(col),
        .req_wdata_in(d), .req_wmask_in(mk), .req_ready_out(rdy), .rd_data_out(rdat),
        .rd_valid_out(rv));
    drb_dev drb_dev_i(.clock_in(clock_in), .rst_in(rst_in), .link(lk), .bl_mode_in(bm),
        .al_in(al), .cl_in(cl), .cwl_in(cwl), .wr_bad_out(bad1));
    drb_dev drb_dev_i2(.clock_in(clock_in), .rst_in(rst_in), .link(lk2), .bl_mode_in(bm),
        .al_in(al2), .cl_in(cl), .cwl_in(cwl), .wr_bad_out(bad2));
    drb_chk #(.RL(RL), .WL(WL)) drb_chk_i(.clock_in(clock_in), .rst_in(rst_in),
        .bl_mode_in(bm), .cmd(lk.cmd), .addr(lk.addr), .ctl_dq_oe_n(lk.ctl_dq_oe_n),
        .ctl_dqs_oe_n(lk.ctl_dqs_oe_n), .ctl_dqs_o(lk.ctl_dqs_o), .ctl_dm_o(lk.ctl_dm_o),
        .dev_dq_oe_n(lk.dev_dq_oe_n), .dev_dqs_o(lk.dev_dqs_o));
    // 100 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // hang guard well above the expected 800 or so cycles; bad write pulses counted
    always @(negedge clock_in) begin
        cyc++;
        if (bad2 === 1'b1) nbad++;
        if (bad1 === 1'b1) nbad1++;
        if (cyc == 8000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one request, held until taken; entered at a falling edge
    task automatic req(input logic wr, input logic [127:0] dat, input logic [15:0] msk);
        v = 1'b1;
        w = wr;
        d = dat;
        mk = msk;
        while (rdy !== 1'b1) @(negedge clock_in);
        @(negedge clock_in);
        v = 1'b0;
        // let an edge pass so a following call never re-raises valid at once
        @(negedge clock_in);
    endtask
    // one chopped write on the fault lane; strobe off breaks its timing
    task automatic lane_wr(input logic [31:0] dat, input logic stb);
        lk2.cmd = DRB_WR;
        @(negedge clock_in) lk2.cmd = DRB_NOP;
        repeat (9) @(negedge clock_in);
        {lk2.ctl_dq_o, lk2.ctl_dqs_o} = {dat, 1'b1};
        {lk2.ctl_dq_oe_n, lk2.ctl_dqs_oe_n} = {1'b0, !stb};
        repeat (2) @(negedge clock_in);
        {lk2.ctl_dq_oe_n, lk2.ctl_dqs_oe_n} = 2'h3;
        repeat (3) @(negedge clock_in);
    endtask
    // masked bytes keep the old value
    function automatic logic [127:0] merge(input logic [127:0] o, n, input logic [15:0] m);
        for (int k = 0; k < 16; k++) merge[8*k+:8] = m[k] ? o[8*k+:8] : n[8*k+:8];
    endfunction
    function automatic logic chop(input logic [1:0] m, input logic b);
        return m == BL_FIX4 || (m == BL_OTF && b);
    endfunction
    initial begin
        int r;
        logic [127:0] base, nw, exp, keep;
        logic [15:0] m2;
        r = $urandom(4159);
        {rst_in, bm, v, w, bc, bk, row, col, d, mk} = {1'b1, 176'h0};
        lk2.cmd = DRB_NOP;
        {lk2.ba, lk2.addr, lk2.ctl_dq_o, lk2.ctl_dm_o, lk2.ctl_dqs_o} = '0;
        {lk2.ctl_dq_oe_n, lk2.ctl_dqs_oe_n} = 2'h3;
        repeat (4) @(negedge clock_in);
        rst_in = 1'b0;
        for (int m = 0; m < 3; m++) begin
            bm = 2'(m);
            for (int i = 0; i < 5; i++) begin
                {bk, row, col, bc} = 28'($urandom);
                if (i == 0) col = 10'h3FF; // corner: top column
                base = {$urandom, $urandom, $urandom, $urandom};
                nw = {$urandom, $urandom, $urandom, $urandom};
                m2 = (i == 1) ? 16'hFFFF : 16'($urandom);
                req(1'b1, base, 16'h0);
                req(1'b1, nw, m2);
                exp = merge(base, nw, m2);
                req(1'b0, ~exp, 16'hFFFF); // read with junk mask
                r = 0;
                while (rv !== 1'b1 && r < 200) begin
                    @(negedge clock_in);
                    r++;
                end
                chk(128'(rv), 128'h1);
                keep = chop(bm, bc) ? {64'h0, {64{1'b1}}} : '1;
                chk(rdat & keep, exp & keep);
            end
        end
        // fault lane: good chopped write, one with no strobe, then a masked read
        lk2.addr = 14'h1000;
        lane_wr(LANE_D, 1'b1);
        chk(128'(nbad), 128'h0);
        lane_wr(~LANE_D, 1'b0);
        chk(128'(nbad != 0), 128'h1);
        lk2.ctl_dm_o = 4'hF;
        lk2.cmd = DRB_RD;
        @(negedge clock_in) lk2.cmd = DRB_NOP;
        repeat (9) @(negedge clock_in);
        chk(128'(lk2.dev_dq_oe_n), 128'h1);
        repeat (2) begin
            @(negedge clock_in);
            chk(128'({lk2.dev_dq_oe_n, lk2.dev_dq_o}), 128'({1'b0, LANE_D}));
        end
        @(negedge clock_in);
        chk(128'(lk2.dev_dq_oe_n), 128'h1);
        chk(128'(nbad1), 128'h0);
        summarize();
    end
endmodule // tb_ddr3_read_write_burst
